// ### verilog/abb_pkg.sv
// Package for the converter output back end: map, fields, codes, types.
// Assumes one sample-clock domain and one serial-port clock domain.
package abb_pkg;
    localparam int          LATENCY      = 9;
    localparam logic [9:0]  BIST_LEN     = 10'h200;
    // Register offsets.
    localparam logic [7:0]  ADDR_CHAN    = 8'h05;
    localparam logic [7:0]  ADDR_POWER   = 8'h08;
    localparam logic [7:0]  ADDR_CLOCK   = 8'h09;
    localparam logic [7:0]  ADDR_PATTERN = 8'h0d;
    localparam logic [7:0]  ADDR_BIST    = 8'h0e;
    localparam logic [7:0]  ADDR_OUTMODE = 8'h14;
    localparam logic [7:0]  ADDR_PHASE   = 8'h16;
    localparam logic [7:0]  ADDR_RESULT  = 8'h24;
    // Field positions.
    localparam int          OUT_DIS_BIT  = 4;
    localparam int          BIST_EN_BIT  = 0;
    localparam int          SEQ_RST_BIT  = 2;
    localparam int          PN_LONG_RST  = 4;
    localparam int          PN_SHORT_RST = 5;
    localparam int          PASS_BIT     = 0;
    localparam int          DCO_INV_BIT  = 7;
    localparam int          DCS_BIT      = 0;
    // Reset values and the CRC polynomial.
    localparam logic [1:0]  CHAN_RST     = 2'h3;
    localparam logic [1:0]  POWER_RST    = 2'h0;
    localparam logic        DCS_RST      = 1'h1;
    localparam logic [7:0]  PATTERN_RST  = 8'h00;
    localparam logic [7:0]  OUTMODE_RST  = 8'h00;
    localparam logic [22:0] PN_LONG_SEED = 23'h7fffff;
    localparam logic [8:0]  PN_SHORT_SEED = 9'h1ff;
    localparam logic [15:0] CRC_INIT     = 16'hffff;
    localparam logic [15:0] CRC_POLY     = 16'h1021;
    // Power modes and output formats.
    localparam logic [1:0]  PWR_DOWN     = 2'h1;
    localparam logic [1:0]  PWR_STANDBY  = 2'h2;
    localparam logic [1:0]  FMT_OFFSET   = 2'h0;
    localparam logic [1:0]  FMT_TWOS     = 2'h1;
    localparam logic [1:0]  FMT_GRAY     = 2'h2;
    // Test patterns, low nibble of the pattern register.
    localparam logic [3:0]  PAT_MID      = 4'h1;
    localparam logic [3:0]  PAT_MAX      = 4'h2;
    localparam logic [3:0]  PAT_MIN      = 4'h3;
    localparam logic [3:0]  PAT_CHECKER  = 4'h4;
    localparam logic [3:0]  PAT_PN_LONG  = 4'h5;
    localparam logic [3:0]  PAT_PN_SHORT = 4'h6;
    localparam logic [3:0]  PAT_TOGGLE   = 4'h7;
    // Codes in offset binary; the core word is signed, in half-step units.
    localparam logic [13:0] CODE_MIN     = 14'h0000;
    localparam logic [13:0] CODE_MID     = 14'h2000;
    localparam logic [13:0] CODE_MAX     = 14'h3fff;
    localparam logic [13:0] CHECKER_A    = 14'h2aaa;
    localparam logic [13:0] CHECKER_B    = 14'h1555;
    localparam logic [15:0] OVR_LOW      = 16'hbfff;
    localparam logic [15:0] OVR_HIGH     = 16'h3fff;

    typedef enum logic [2:0] {
        BIST_IDLE = 3'b001,
        BIST_RUN  = 3'b010,
        BIST_DONE = 3'b100
    } abb_bist_state_t;

    typedef struct packed {
        logic [13:0] code;
        logic        ovr;
        logic        raw;
        logic        bist;
    } abb_stage_t;

    typedef struct packed {
        logic power_down;
        logic out_disable;
        logic fmt_strap;
        logic dcs_strap;
        logic cs_n;
    } abb_pins_t;

    typedef struct packed {
        logic       we;
        logic [7:0] addr;
        logic [7:0] wdata;
    } abb_req_t;
endpackage

// ### verilog/abb_backend.sv
// Converter output back end: format, overrange, latency pipe, self-test,
// test patterns, power and three-state control, register file.
// Assumes the serial protocol decoder delivers byte accesses on serial_clock.
//
// Function
// [RULE1] Power down by register or high power-down pin; pin low resumes.
// [RULE2] Powered down, all output drivers are high impedance.
// [RULE3] Register standby keeps the reference powered for quick wake-up.
// [RULE4] Pin mode: format strap low offset binary, high twos complement.
// [RULE5] Pin mode: stabilizer strap low disables, high enables it.
// [RULE6] Register mode picks offset binary, twos complement or gray.
// [RULE7] Output-disable pin high three-states data and data clocks.
// [RULE8] Output mode bit 4 three-states each channel on its own.
// [RULE9] Results appear nine sample clocks after sampling.
// [RULE10] Outputs update on the rising sample clock edge.
// [RULE11] Capture on rising data clock, falling when inverted.
// [RULE12] Offset binary spans zero to all ones; twos complement flips the top bit.
// [RULE13] Beyond full scale by over half a step: saturate, flag overrange.
// [RULE14] Self-test injects pseudorandom data and builds an output CRC.
// [RULE15] Self-test runs 512 cycles; result bit 0 shows a signature match.
// [RULE16] Writing 0x05 to self-test control starts from a fresh seed.
// [RULE17] The self-test enable bit clears itself on completion.
// [RULE18] Sequence-reset bit zero continues the generator.
// [RULE19] Data outputs stay active during self-test.
// [RULE20] A selected pattern replaces converter data through the formatter; checker, PN and toggle patterns bypass it.
// [RULE21] Pattern bits 4 and 5 reset the pattern generators.
// [RULE22] Patterns ignore the analog input and need the sample clock.
// [RULE23] Pin mode relies on chip select held high outside.
`timescale 1ns/100ps

module abb_backend
    import abb_pkg::*;
#(
    parameter logic [15:0] BIST_SIGNATURE = 16'h0000
)
(
    input  wire logic              clock,
    input  wire logic              sys_rst,
    input  wire logic              serial_clock,
    input  wire logic              reg_write,
    input  wire logic              reg_read,
    input  wire logic [7:0]        reg_addr,
    input  wire logic [7:0]        reg_wdata,
    output logic      [7:0]        reg_rdata,
    output logic                   reg_rvalid,
    output logic                   reg_busy,
    input  wire logic              chip_select_n,
    input  wire logic              power_down_pin,
    input  wire logic              output_disable_n,
    input  wire logic              format_select_strap,
    input  wire logic              stabilizer_strap,
    input  wire logic [1:0][15:0]  core_word,
    output logic      [1:0][13:0]  data_out,
    output logic      [1:0]        overrange,
    output logic      [1:0]        data_oe,
    output logic      [1:0]        data_clock_out,
    output logic      [1:0]        data_clock_oe,
    output logic                   duty_cycle_stabilizer,
    output logic                   reference_power_on,
    output logic                   core_power_on
);

    typedef struct packed {
        abb_pins_t                     pin_s1;
        abb_pins_t                     pin_s2;
        logic [2:0]                    req_sync;
        logic                          ack_tog;
        logic [7:0]                    resp;
        logic [1:0]                    chan_sel;
        logic [1:0]                    power;
        logic                          dcs_en;
        logic [7:0]                    pattern;
        logic                          bist_en;
        logic                          seq_reset;
        logic [1:0][7:0]               out_mode;
        logic                          dco_inv;
        logic                          pass;
        logic                          cfg_written;
        abb_bist_state_t               bist_state;
        logic [9:0]                    inj_cnt;
        logic [9:0]                    acc_cnt;
        logic [15:0]                   crc;
        logic [22:0]                   pn_long;
        logic [8:0]                    pn_short;
        logic                          phase;
        abb_stage_t [LATENCY-1:0][1:0] pipe;
        logic [1:0][13:0]              data;
        logic [1:0]                    ovr;
        logic [1:0]                    data_oe;
        logic [1:0]                    dco_oe;
        logic                          dcs_out;
        logic                          ref_on;
        logic                          core_on;
    } abb_core_t;

    typedef struct packed {
        abb_req_t   req;
        logic       req_tog;
        logic [1:0] ack_s;
        logic       ack_d;
        logic       busy;
        logic [7:0] rdata;
        logic       rvalid;
    } abb_serial_t;

    abb_core_t   s_reg;
    abb_core_t   s_next;
    abb_serial_t p_reg;
    abb_serial_t p_next;

    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [13:0] d);
        logic [15:0] r;
        logic        fb;
        r = c;
        for (int i = 13; i >= 0; i--)
        begin
            fb = r[15] ^ d[i];
            r = {r[14:0], 1'b0} ^ (fb ? CRC_POLY : 16'h0000);
        end
        return r;
    endfunction

    function automatic logic [13:0] format_code(input abb_stage_t st, input logic [1:0] mode);
        logic [13:0] r;
        r = st.code;
        if (!st.raw)
        begin
            case (mode)
                FMT_TWOS: r = {~st.code[13], st.code[12:0]}; // RULE12
                FMT_GRAY: r = st.code ^ {1'b0, st.code[13:1]};
                default:  r = st.code;
            endcase
        end
        return r;
    endfunction

    // Serial side: one access in flight; the answer returns by toggle.
    always_comb
    begin
        p_next = p_reg;
        p_next.rvalid = 1'b0;
        p_next.ack_s = {p_reg.ack_s[0], s_reg.ack_tog};
        p_next.ack_d = p_reg.ack_s[1];
        if (p_reg.ack_s[1] != p_reg.ack_d)
        begin
            p_next.busy = 1'b0;
            p_next.rdata = p_reg.req.we ? p_reg.rdata : s_reg.resp;
            p_next.rvalid = !p_reg.req.we;
        end
        if (!p_reg.busy && (reg_write || reg_read))
        begin
            p_next.req = '{we: reg_write, addr: reg_addr, wdata: reg_wdata};
            p_next.req_tog = ~p_reg.req_tog;
            p_next.busy = 1'b1;
        end
    end

    always_ff @(posedge serial_clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            p_reg <= '0;
        end
        else
        begin
            p_reg <= p_next;
        end
    end

    // Sample side.
    always_comb
    begin
        logic        pin_mode;
        logic        pd;
        logic        sb;
        logic        inject;
        logic [1:0]  fmt;
        logic [16:0] half;
        logic [15:0] v;
        logic [13:0] cw;
        abb_req_t    rq;
        s_next = s_reg;
        // Straps count only while no register has been written.
        pin_mode = s_reg.pin_s2.cs_n && !s_reg.cfg_written; // RULE23
        pd = s_reg.pin_s2.power_down || (s_reg.power == PWR_DOWN); // RULE1
        sb = (s_reg.power == PWR_STANDBY); // RULE3
        inject = (s_reg.bist_state == BIST_RUN) && (s_reg.inj_cnt != BIST_LEN);
        fmt = FMT_OFFSET;
        half = '0;
        v = '0;
        cw = '0;
        rq = p_reg.req;

        s_next.pin_s1 = '{power_down: power_down_pin, out_disable: output_disable_n,
                          fmt_strap: format_select_strap, dcs_strap: stabilizer_strap,
                          cs_n: chip_select_n};
        s_next.pin_s2 = s_reg.pin_s1;
        s_next.req_sync = {s_reg.req_sync[1:0], p_reg.req_tog};

        s_next.ref_on = !pd; // RULE3
        s_next.core_on = !(pd || sb);
        s_next.dcs_out = pin_mode ? s_reg.pin_s2.dcs_strap : s_reg.dcs_en; // RULE5

        // Generators step only while something consumes them.
        if (inject || s_reg.pattern[3:0] == PAT_PN_LONG)
        begin
            s_next.pn_long = {s_reg.pn_long[21:0], s_reg.pn_long[22] ^ s_reg.pn_long[17]};
        end
        if (s_reg.pattern[3:0] == PAT_PN_SHORT)
        begin
            s_next.pn_short = {s_reg.pn_short[7:0], s_reg.pn_short[8] ^ s_reg.pn_short[4]};
        end
        if (s_reg.pattern[PN_LONG_RST])
        begin
            s_next.pn_long = PN_LONG_SEED; // RULE21
        end
        if (s_reg.pattern[PN_SHORT_RST])
        begin
            s_next.pn_short = PN_SHORT_SEED; // RULE21
        end
        s_next.phase = ~s_reg.phase;

        s_next.pipe[LATENCY-1:1] = s_reg.pipe[LATENCY-2:0]; // RULE9
        for (int ch = 0; ch < 2; ch++)
        begin
            v = core_word[ch];
            half = {{2{v[15]}}, v[15:1]} + 17'h02000;
            cw = half[16] ? CODE_MIN : (half[15:14] != 2'h0) ? CODE_MAX : half[13:0]; // RULE13
            s_next.pipe[0][ch] = '{code: cw, ovr: ($signed(v) < $signed(OVR_LOW)) ||
                                   ($signed(v) > $signed(OVR_HIGH)), raw: 1'b0, bist: 1'b0}; // RULE13
            if (inject)
            begin
                s_next.pipe[0][ch] = '{code: s_reg.pn_long[13:0], ovr: 1'b0, raw: 1'b0, bist: 1'b1}; // RULE14
            end
            else
            begin
                // The core word is dropped whenever a pattern is active.
                case (s_reg.pattern[3:0]) // RULE20 RULE22
                    PAT_MID:      s_next.pipe[0][ch] = '{CODE_MID, 1'b0, 1'b0, 1'b0};
                    PAT_MAX:      s_next.pipe[0][ch] = '{CODE_MAX, 1'b0, 1'b0, 1'b0};
                    PAT_MIN:      s_next.pipe[0][ch] = '{CODE_MIN, 1'b0, 1'b0, 1'b0};
                    PAT_CHECKER:  s_next.pipe[0][ch] = '{s_reg.phase ? CHECKER_B : CHECKER_A,
                                                         1'b0, 1'b1, 1'b0};
                    PAT_PN_LONG:  s_next.pipe[0][ch] = '{s_reg.pn_long[13:0], 1'b0, 1'b1, 1'b0};
                    PAT_PN_SHORT: s_next.pipe[0][ch] = '{{s_reg.pn_short, s_reg.pn_short[8:4]},
                                                         1'b0, 1'b1, 1'b0};
                    PAT_TOGGLE:   s_next.pipe[0][ch] = '{s_reg.phase ? CODE_MIN : CODE_MAX,
                                                         1'b0, 1'b1, 1'b0};
                    default:      ;
                endcase
            end

            fmt = pin_mode ? (s_reg.pin_s2.fmt_strap ? FMT_TWOS : FMT_OFFSET) // RULE4
                           : s_reg.out_mode[ch][1:0]; // RULE6
            s_next.data[ch] = format_code(s_reg.pipe[LATENCY-1][ch], fmt); // RULE10
            s_next.ovr[ch] = s_reg.pipe[LATENCY-1][ch].ovr;
            // Self-test does not touch the enables, so its data stays visible.
            s_next.data_oe[ch] = !(pd || sb) && !s_reg.pin_s2.out_disable // RULE2 RULE7 RULE19
                                 && !s_reg.out_mode[ch][OUT_DIS_BIT]; // RULE8
            s_next.dco_oe[ch] = s_next.data_oe[ch]; // RULE7 RULE8
        end

        // Signature over the formatted words leaving the pipe.
        case (s_reg.bist_state)
            BIST_IDLE: s_next.inj_cnt = '0;
            BIST_RUN:
            begin
                s_next.inj_cnt = s_reg.inj_cnt + {9'h000, inject};
                if (s_reg.pipe[LATENCY-1][0].bist)
                begin
                    s_next.crc = crc_step(crc_step(s_reg.crc, s_next.data[0]), s_next.data[1]); // RULE14
                    s_next.acc_cnt = s_reg.acc_cnt + 10'h001;
                    if (s_reg.acc_cnt == BIST_LEN - 10'h001)
                    begin
                        s_next.bist_state = BIST_DONE; // RULE15
                    end
                end
            end
            BIST_DONE:
            begin
                s_next.pass = (s_reg.crc == BIST_SIGNATURE); // RULE15
                s_next.bist_en = 1'b0; // RULE17
                s_next.bist_state = BIST_IDLE;
            end
            default: s_next.bist_state = BIST_IDLE;
        endcase

        // Register access comes last so a software write beats hardware clears.
        if (s_reg.req_sync[1] != s_reg.req_sync[2])
        begin
            s_next.ack_tog = ~s_reg.ack_tog;
            case (rq.addr)
                ADDR_CHAN:    s_next.resp = {6'h00, s_reg.chan_sel};
                ADDR_POWER:   s_next.resp = {6'h00, s_reg.power};
                ADDR_CLOCK:   s_next.resp = {7'h00, s_reg.dcs_en};
                ADDR_PATTERN: s_next.resp = s_reg.pattern;
                ADDR_BIST:    s_next.resp = {5'h00, s_reg.seq_reset, 1'b0, s_reg.bist_en};
                ADDR_OUTMODE: s_next.resp = s_reg.chan_sel[0] ? s_reg.out_mode[0] : s_reg.out_mode[1];
                ADDR_PHASE:   s_next.resp = {s_reg.dco_inv, 7'h00};
                ADDR_RESULT:  s_next.resp = {7'h00, s_reg.pass};
                default:      s_next.resp = 8'h00;
            endcase
            if (rq.we)
            begin
                s_next.cfg_written = 1'b1;
                case (rq.addr)
                    ADDR_CHAN:    s_next.chan_sel = rq.wdata[1:0];
                    ADDR_POWER:   s_next.power = rq.wdata[1:0]; // RULE1 RULE3
                    ADDR_CLOCK:   s_next.dcs_en = rq.wdata[DCS_BIT];
                    ADDR_PATTERN: s_next.pattern = rq.wdata; // RULE20
                    ADDR_BIST:
                    begin
                        s_next.bist_en = rq.wdata[BIST_EN_BIT];
                        s_next.seq_reset = rq.wdata[SEQ_RST_BIT];
                        s_next.bist_state = BIST_IDLE;
                        if (rq.wdata[BIST_EN_BIT])
                        begin
                            s_next.bist_state = BIST_RUN; // RULE16
                            s_next.inj_cnt = '0;
                            s_next.acc_cnt = '0;
                            s_next.crc = CRC_INIT;
                            s_next.pn_long = rq.wdata[SEQ_RST_BIT] ? PN_LONG_SEED : s_reg.pn_long; // RULE16 RULE18
                        end
                    end
                    ADDR_OUTMODE:
                    begin
                        for (int ch = 0; ch < 2; ch++)
                        begin
                            if (s_reg.chan_sel[ch])
                            begin
                                s_next.out_mode[ch] = rq.wdata; // RULE8 RULE6
                            end
                        end
                    end
                    ADDR_PHASE:   s_next.dco_inv = rq.wdata[DCO_INV_BIT]; // RULE11
                    default:      ;
                endcase
            end
        end
    end

    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            s_reg <= '0;
            s_reg.chan_sel <= CHAN_RST;
            s_reg.power <= POWER_RST;
            s_reg.dcs_en <= DCS_RST;
            s_reg.pattern <= PATTERN_RST;
            s_reg.out_mode <= {OUTMODE_RST, OUTMODE_RST};
            s_reg.bist_state <= BIST_IDLE;
            s_reg.crc <= CRC_INIT;
            s_reg.pn_long <= PN_LONG_SEED;
            s_reg.pn_short <= PN_SHORT_SEED;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    // Forwarded sample clock: by default it rises mid-eye, half a cycle
    // after the data changed on the rising sample edge.
    assign data_clock_out        = {2{~clock ^ s_reg.dco_inv}}; // RULE11
    assign data_clock_oe         = s_reg.dco_oe;
    assign data_out              = s_reg.data;
    assign overrange             = s_reg.ovr;
    assign data_oe               = s_reg.data_oe;
    assign duty_cycle_stabilizer = s_reg.dcs_out;
    assign reference_power_on    = s_reg.ref_on;
    assign core_power_on         = s_reg.core_on;
    assign reg_rdata             = p_reg.rdata;
    assign reg_rvalid            = p_reg.rvalid;
    assign reg_busy              = p_reg.busy;

endmodule

// ### verilog/abb_unused.sv
`timescale 1ns/100ps
// No logic here.

// ### test/abb_backend_properties.sv
// Port assertions for the converter output back end.
// Bound into abb_backend; sees pins, enables and power levels only.
`timescale 1ns/100ps
module abb_backend_properties
(
    input  wire logic       clock,
    input  wire logic       sys_rst,
    input  wire logic       serial_clock,
    input  wire logic       reg_write,
    input  wire logic       chip_select_n,
    input  wire logic       power_down_pin,
    input  wire logic       output_disable_n,
    input  wire logic       stabilizer_strap,
    input  wire logic [1:0] data_oe,
    input  wire logic [1:0] data_clock_oe,
    input  wire logic       duty_cycle_stabilizer,
    input  wire logic       reference_power_on,
    input  wire logic       core_power_on
);
    // Any write ends pin mode for good, so pin-only relations stop there.
    logic wrote_reg;
    always_ff @(posedge serial_clock or posedge sys_rst)
        if (sys_rst)
            wrote_reg <= 1'b0;
        else if (reg_write)
            wrote_reg <= 1'b1;
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    power_down_pin_outputs_a: assert property (
        power_down_pin [*4] |=> data_oe == 2'h0) else $error("outputs driven in power down");
    power_down_pin_core_a: assert property (
        power_down_pin [*4] |=> !core_power_on) else $error("core on with pin high");
    wake_core_a: assert property (
        (!wrote_reg && !power_down_pin) [*4] |=> core_power_on) else $error("core stays off");
    disable_pin_a: assert property (
        output_disable_n [*4] |=> {data_oe, data_clock_oe} == 4'h0) else $error("outputs not released");
    enable_pin_a: assert property (
        (!wrote_reg && !output_disable_n && !power_down_pin) [*4] |=> data_oe == 2'h3) else $error("outputs idle");
    dco_follows_a: assert property (
        data_clock_oe == data_oe) else $error("clock enable differs");
    strap_dcs_a: assert property (
        (!wrote_reg && chip_select_n && $stable(stabilizer_strap)) [*4]
        |=> duty_cycle_stabilizer == $past(stabilizer_strap)) else $error("stabilizer ignores strap");
    standby_ref_a: assert property (
        core_power_on |-> reference_power_on) else $error("core on without reference");
    drive_core_a: assert property (
        data_oe != 2'h0 |-> core_power_on || $past(core_power_on)) else $error("driving while down");
endmodule
bind abb_backend abb_backend_properties i_props (.clock, .sys_rst, .serial_clock, .reg_write, .chip_select_n,
    .power_down_pin, .output_disable_n, .stabilizer_strap, .data_oe, .data_clock_oe, .duty_cycle_stabilizer,
    .reference_power_on, .core_power_on);

// ### test/abb_capture_model.sv
// Capture register on the far side of the parallel data bus.
// Clocked by the data clock outputs; sees drivers through their enables.
`timescale 1ns/100ps
module abb_capture_model
(
    input  wire logic [1:0]       data_clock_out,
    input  wire logic [1:0]       data_oe,
    input  wire logic [1:0][13:0] data_out,
    output logic      [1:0][13:0] captured
);
    for (genvar c = 0; c < 2; c++)
    begin : g_ch
        // A released bus shows the inverse of the previous capture, so every second edge gives a clean copy.
        always @(posedge data_clock_out[c])
            captured[c] <= data_oe[c] ? data_out[c] : ~captured[c];
    end
endmodule

// ### test/testbench.sv
// Self-checking bench for the converter back end.
// Drives pins, core words and the register port; compares with a model.
`timescale 1ns/100ps
module testbench
    import abb_pkg::*;
;
    logic clock = 0, sys_rst = 1, serial_clock = 0, reg_write = 0, reg_read = 0, chk = 0, hold = 0, arm = 0;
    logic chip_select_n = 1, power_down_pin = 0, output_disable_n = 0, format_select_strap = 0, stabilizer_strap = 1;
    logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata, q;
    logic [1:0][15:0] core_word = '0, hist [10];
    logic [1:0][13:0] data_out, captured;
    logic [1:0] overrange, data_oe, data_clock_out, data_clock_oe;
    logic reg_rvalid, reg_busy, duty_cycle_stabilizer, reference_power_on, core_power_on;
    logic [13:0] w, a, b, pc [4] = '{14'h0, CODE_MID, CODE_MAX, CODE_MIN};
    int fails = 0, n_checks = 0, seed = 95, fmt = 0, r;
    always #20 clock = ~clock;
    initial #7 forever #62.5 serial_clock = ~serial_clock;
    abb_backend i_dut (.clock, .sys_rst, .serial_clock, .reg_write, .reg_read, .reg_addr, .reg_wdata, .reg_rdata,
        .reg_rvalid, .reg_busy, .chip_select_n, .power_down_pin, .output_disable_n, .format_select_strap,
        .stabilizer_strap, .core_word, .data_out, .overrange, .data_oe, .data_clock_out, .data_clock_oe,
        .duty_cycle_stabilizer, .reference_power_on, .core_power_on);
    abb_capture_model i_cap (.data_clock_out, .data_oe, .data_out, .captured);
    function automatic logic [15:0] model(input logic [15:0] v, input int f);
        int iv, c;
        logic [13:0] o;
        iv = int'($signed(v));
        c = (iv >>> 1) + 8192;
        o = (c < 0) ? 14'h0 : (c > 16383) ? 14'h3fff : c[13:0];
        if (f == 1) o[13] = ~o[13];
        if (f == 2) o = o ^ (o >> 1);
        return {1'b0, iv < -16385 || iv > 16383, o};
    endfunction
    task automatic cmp(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict;
        if (fails == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic acc(input logic wr, input logic [7:0] ad, input logic [7:0] d);
        int n = 0;
        @(posedge serial_clock);
        reg_addr <= ad;
        reg_wdata <= d;
        reg_write <= wr;
        reg_read <= !wr;
        @(posedge serial_clock);
        reg_write <= 1'b0;
        reg_read <= 1'b0;
        do
        begin
            @(posedge serial_clock);
            n++;
            if (n > 99) begin fails++; give_verdict(); end
        end while (wr ? reg_busy !== 1'b0 : reg_rvalid !== 1'b1);
        q = reg_rdata;
    endtask
    task automatic phase(input int f);
        fmt <= f;
        repeat (20) @(posedge clock);
        chk <= 1'b1;
        repeat (50) @(posedge clock);
        chk <= 1'b0;
    endtask
    task automatic run(input logic [7:0] d);
        int n = 0;
        arm = 1'b1;
        acc(1, ADDR_BIST, d);
        do
        begin
            acc(0, ADDR_BIST, 8'h00);
            n++;
        end while (q[BIST_EN_BIT] !== 1'b0 && n < 60);
        cmp(16'(n < 60), 16'h1);
        acc(0, ADDR_RESULT, 8'h00);
        cmp(q[PASS_BIT], 16'h0);
    endtask
    always @(posedge clock)
    begin
        r = $random(seed);
        core_word <= hold ? 32'h0 : 32'(r);
        for (int i = 9; i > 0; i--) hist[i] <= hist[i-1];
        hist[0] <= core_word;
        for (int c = 0; c < 2; c++)
            if (chk) cmp({overrange[c], captured[c]}, model(hist[9][c], fmt));
        if (arm && data_out[0] !== CODE_MID)
        begin
            w <= data_out[0];
            arm <= 1'b0;
            cmp(data_oe, 16'h3);
        end
    end
    initial
    begin
        repeat (12) @(posedge clock);
        sys_rst <= 1'b0;
        for (int s = 0; s < 2; s++)
        begin
            format_select_strap <= s[0];
            phase(s);
        end
        output_disable_n <= 1'b1;
        repeat (6) @(posedge clock);
        cmp({data_oe, data_clock_oe}, 16'h0);
        output_disable_n <= 1'b0;
        power_down_pin <= 1'b1;
        stabilizer_strap <= 1'b0;
        repeat (6) @(posedge clock);
        cmp({core_power_on, data_oe, duty_cycle_stabilizer}, 16'h0);
        power_down_pin <= 1'b0;
        stabilizer_strap <= 1'b1;
        repeat (8) @(posedge clock);
        cmp({core_power_on, data_oe, duty_cycle_stabilizer}, 16'hf);
        chip_select_n <= 1'b0;
        for (int f = 0; f < 3; f++)
        begin
            acc(1, ADDR_OUTMODE, 8'(f));
            phase(f);
        end
        acc(1, ADDR_CHAN, 8'h01);
        acc(1, ADDR_OUTMODE, 8'h10);
        repeat (8) @(posedge clock);
        cmp({data_oe, data_clock_oe}, 16'ha);
        acc(1, ADDR_CHAN, 8'h03);
        acc(1, ADDR_OUTMODE, 8'h01);
        acc(1, ADDR_POWER, 8'h02);
        repeat (8) @(posedge clock);
        cmp({reference_power_on, core_power_on, data_oe}, 16'h8);
        acc(1, ADDR_POWER, 8'h01);
        repeat (8) @(posedge clock);
        cmp({reference_power_on, core_power_on}, 16'h0);
        acc(1, ADDR_POWER, 8'h00);
        for (int p = 1; p < 4; p++)
        begin
            acc(1, ADDR_PATTERN, 8'(p));
            repeat (20) @(posedge clock);
            cmp(data_out[1], pc[p] ^ 14'h2000);
        end
        acc(1, ADDR_PATTERN, {4'h0, PAT_CHECKER});
        repeat (20) @(posedge clock);
        cmp(16'(data_out[0] == CHECKER_A || data_out[0] == CHECKER_B), 16'h1);
        acc(1, ADDR_PATTERN, 8'h15);
        repeat (20) @(posedge clock);
        a = data_out[0];
        repeat (3) @(posedge clock);
        cmp(data_out[0], a);
        acc(1, ADDR_PATTERN, 8'h00);
        acc(1, ADDR_OUTMODE, 8'h00);
        hold <= 1'b1;
        repeat (20) @(posedge clock);
        run(8'h05);
        a = w;
        run(8'h01);
        b = w;
        run(8'h05);
        cmp(w, a);
        cmp(16'(b !== a), 16'h1);
        give_verdict();
    end
endmodule
